// file: design/wqem_pkg.sv
// Purpose: Shared constants and types for the write queue event monitor.
// Assumes: One controller clock, synchronous active-high reset.
// Notes:   Event codes and unit mask bit positions select the counted condition.

// ==========================================================================
// Package
package wqem_pkg;

  // ========================================================================
  // Sizes
  localparam int WQEM_DEPTH     = 40;
  localparam int WQEM_PCH_DEPTH = 20;
  localparam int WQEM_AW        = 32;
  localparam int WQEM_BEW       = 8;
  localparam int WQEM_BYTE      = 8;
  localparam int WQEM_DW        = WQEM_BEW * WQEM_BYTE;
  localparam int WQEM_ADRW      = 8;
  localparam int WQEM_CW        = 32;

  // ========================================================================
  // Event codes
  localparam logic [7:0] WQEM_EV_TAG_CHECK   = 8'hd3;
  localparam logic [7:0] WQEM_EV_FULL_PSEUDO_CHANNEL_ZERO   = 8'h22;
  localparam logic [7:0] WQEM_EV_FULL_PSEUDO_CHANNEL_ONE   = 8'h16;
  localparam logic [7:0] WQEM_EV_NONEMPTY    = 8'h21;
  localparam logic [7:0] WQEM_EV_ALLOC       = 8'h20;
  localparam logic [7:0] WQEM_EV_OCC_PSEUDO_CHANNEL_ZERO    = 8'h82;
  localparam logic [7:0] WQEM_EV_OCC_PSEUDO_CHANNEL_ONE    = 8'h83;
  localparam logic [7:0] WQEM_EV_READ_MATCH  = 8'h23;
  localparam logic [7:0] WQEM_EV_WRITE_MATCH = 8'h24;

  // ========================================================================
  // Unit mask bits
  localparam int WQEM_UM_HIT        = 0;
  localparam int WQEM_UM_CLEAN_MISS = 1;
  localparam int WQEM_UM_DIRTY_MISS = 2;
  localparam int WQEM_UM_READ_HIT   = 3;
  localparam int WQEM_UM_WRITE_HIT  = 4;
  localparam int WQEM_UM_TAG_W      = 5;
  localparam int WQEM_UM_PSEUDO_CHANNEL_ZERO       = 0;
  localparam int WQEM_UM_PSEUDO_CHANNEL_ONE       = 1;
  localparam int WQEM_UM_NOT_POSTED = 0;
  localparam int WQEM_UM_POSTED     = 1;

  // ========================================================================
  // Register map and fields
  localparam logic [WQEM_ADRW-1:0] WQEM_OFF_CTL  = 8'h00;
  localparam logic [WQEM_ADRW-1:0] WQEM_OFF_CNT  = 8'h04;
  localparam logic [WQEM_ADRW-1:0] WQEM_OFF_STAT = 8'h08;
  localparam int WQEM_CTL_EV_LSB   = 0;
  localparam int WQEM_CTL_UM_LSB   = 8;
  localparam int WQEM_CTL_EN_BIT   = 22;
  localparam int WQEM_ST_OCC1_LSB  = 8;
  localparam int WQEM_ST_FULL0_BIT = 16;
  localparam int WQEM_ST_FULL1_BIT = 17;
  localparam int WQEM_ST_BUSY_BIT  = 18;
  localparam logic [31:0] WQEM_CTL_RST = 32'h0;
  localparam logic [31:0] WQEM_CNT_RST = 32'h0;

  // ========================================================================
  // Issue state machine
  typedef enum logic [1:0] {
    WQEM_ISS_IDLE = 2'b01,
    WQEM_ISS_SEND = 2'b10
  } wqem_iss_t;

endpackage : wqem_pkg

// file: design/wqem_mem.sv
// Purpose: Data store of the write queue with byte-masked writes.
// Assumes: Two registered read ports, one write port.
// Notes:   A read and a write to one entry in the same cycle return the old data.

// ==========================================================================
// Module
module wqem_mem #(
  parameter int DEPTH = wqem_pkg::WQEM_DEPTH,
  parameter int BEW   = wqem_pkg::WQEM_BEW,
  parameter int DW    = wqem_pkg::WQEM_DW
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Write port
  input  wire logic                     wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
  input  wire logic [BEW-1:0]           wr_be_i,
  input  wire logic [DW-1:0]            wr_data_i,
  // Read port a
  input  wire logic                     rda_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] rda_idx_i,
  output logic      [DW-1:0]            rda_data_o,
  // Read port b
  input  wire logic                     rdb_en_i,
  input  wire logic [$clog2(DEPTH)-1:0] rdb_idx_i,
  output logic      [DW-1:0]            rdb_data_o
);
  import wqem_pkg::*;

  logic [DW-1:0] mem_r [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      for (int b = 0; b < BEW; b++) begin
        if (wr_be_i[b]) begin
          mem_r[wr_idx_i][b*WQEM_BYTE +: WQEM_BYTE] <= wr_data_i[b*WQEM_BYTE +: WQEM_BYTE];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rda_data_o <= '0;
      rdb_data_o <= '0;
    end else begin
      if (rda_en_i) begin
        rda_data_o <= mem_r[rda_idx_i];
      end
      if (rdb_en_i) begin
        rdb_data_o <= mem_r[rdb_idx_i];
      end
    end
  end

endmodule : wqem_mem

// file: design/wqem_monitor.sv
// Purpose: Posted write queue with address search and its event counter.
// Assumes: Wishbone classic slave, single clock, requests synchronous to it.
// Notes:   One counter; event code and unit mask are set in the control word.
//
// Design decisions made here: the address map and register access over Wishbone.

// ==========================================================================
// Module
module wqem_monitor #(
  parameter int DEPTH     = wqem_pkg::WQEM_DEPTH,
  parameter int PCH_DEPTH = wqem_pkg::WQEM_PCH_DEPTH,
  parameter int AW        = wqem_pkg::WQEM_AW,
  parameter int BEW       = wqem_pkg::WQEM_BEW
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [wqem_pkg::WQEM_ADRW-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  // Near cache tag check
  input  wire logic                          tag_valid_i,
  input  wire logic                          tag_hit_i,
  input  wire logic                          tag_dirty_i,
  input  wire logic                          tag_write_i,
  // Writes from the home agent side
  input  wire logic                          wr_valid_i,
  input  wire logic                          wr_pch_i,
  input  wire logic [AW-1:0]                 wr_addr_i,
  input  wire logic [BEW-1:0]                wr_be_i,
  input  wire logic [BEW*wqem_pkg::WQEM_BYTE-1:0] wr_data_i,
  output logic                               wr_cmp_o,
  output logic                               credit_ret_o,
  output logic                               credit_ret_pch_o,
  // Reads
  input  wire logic                          rd_valid_i,
  input  wire logic                          rd_pch_i,
  input  wire logic [AW-1:0]                 rd_addr_i,
  output logic                               rd_hit_o,
  output logic [BEW*wqem_pkg::WQEM_BYTE-1:0] rd_data_o,
  output logic                               dram_rd_valid_o,
  output logic                               dram_rd_pch_o,
  output logic      [AW-1:0]                 dram_rd_addr_o,
  // DRAM write issue
  output logic                               dram_wr_valid_o,
  input  wire logic                          dram_wr_ready_i,
  output logic                               dram_wr_pch_o,
  output logic      [AW-1:0]                 dram_wr_addr_o,
  output logic      [BEW-1:0]                dram_wr_be_o,
  output logic [BEW*wqem_pkg::WQEM_BYTE-1:0] dram_wr_data_o
);
  import wqem_pkg::*;

  localparam int IW   = $clog2(DEPTH);
  localparam int CNTW = $clog2(DEPTH + 1);

  // ========================================================================
  // Functions
  function automatic logic [IW-1:0] first_set(input logic [DEPTH-1:0] v);
    first_set = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (v[i]) first_set = IW'(i);
    end
  endfunction : first_set

  function automatic logic [CNTW-1:0] pop_count(input logic [DEPTH-1:0] v);
    pop_count = '0;
    for (int i = 0; i < DEPTH; i++) begin
      pop_count = pop_count + CNTW'(v[i]);
    end
  endfunction : pop_count

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      byte_merge[b*WQEM_BYTE +: WQEM_BYTE] = sel[b] ? new_v[b*WQEM_BYTE +: WQEM_BYTE]
                                                    : old_v[b*WQEM_BYTE +: WQEM_BYTE];
    end
  endfunction : byte_merge

  // ========================================================================
  // Queue state
  logic [DEPTH-1:0] valid_r;
  logic [DEPTH-1:0] posted_r;
  logic [DEPTH-1:0] pch_r;
  logic [AW-1:0]    addr_r [DEPTH];
  logic [BEW-1:0]   be_r   [DEPTH];
  wqem_iss_t        state_r;
  logic [IW-1:0]    infl_r;
  logic [31:0]      ctl_r;
  logic [31:0]      cnt_r;
  logic             ack_r;
  logic [DEPTH-1:0] wmatch_w;
  logic [DEPTH-1:0] rmatch_w;

  // The write must not merge into an entry whose data is already on its way to DRAM.
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      wmatch_w[i] = valid_r[i] && addr_r[i] == wr_addr_i && pch_r[i] == wr_pch_i;
      rmatch_w[i] = valid_r[i] && addr_r[i] == rd_addr_i && pch_r[i] == rd_pch_i;
    end
  end

  wire [CNTW-1:0]  cnt0_w     = pop_count(valid_r & ~pch_r);
  wire [CNTW-1:0]  cnt1_w     = pop_count(valid_r & pch_r);
  wire             full0_w    = cnt0_w == CNTW'(PCH_DEPTH);
  wire             full1_w    = cnt1_w == CNTW'(PCH_DEPTH);
  wire [DEPTH-1:0] cand_w     = valid_r & posted_r;
  wire             cand_any_w = |cand_w;
  wire [IW-1:0]    pick_w     = first_set(cand_w);
  wire             busy_w     = state_r == WQEM_ISS_SEND;
  wire             iss_go_w   = state_r == WQEM_ISS_IDLE && cand_any_w;
  wire             iss_done_w = busy_w && dram_wr_ready_i;
  wire [DEPTH-1:0] infl_vec_w = busy_w ? (DEPTH'(1) << infl_r)
                              : (cand_any_w ? (DEPTH'(1) << pick_w) : '0);
  wire [DEPTH-1:0] whit_vec_w = wmatch_w & ~infl_vec_w;
  wire             wr_hit_w   = |whit_vec_w;
  wire [IW-1:0]    wr_hidx_w  = first_set(whit_vec_w);
  wire             wr_full_w  = wr_pch_i ? full1_w : full0_w;
  wire             wr_take_w  = wr_valid_i && !wr_hit_w && !wr_full_w;
  wire             merge_w    = wr_valid_i && wr_hit_w;
  wire [IW-1:0]    free_idx_w = first_set(~valid_r);
  wire [DEPTH-1:0] rpref_w    = rmatch_w & ~infl_vec_w;
  wire             rd_hit_w   = |rmatch_w;
  wire [IW-1:0]    rd_idx_w   = first_set((|rpref_w) ? rpref_w : rmatch_w);
  wire [DEPTH-1:0] free_vec_w = iss_done_w ? (DEPTH'(1) << infl_r) : '0;
  wire [DEPTH-1:0] alloc_vec_w = wr_take_w ? (DEPTH'(1) << free_idx_w) : '0;
  wire [DEPTH-1:0] valid_nxt  = (valid_r & ~free_vec_w) | alloc_vec_w;
  wire [DEPTH-1:0] posted_nxt = valid_nxt & valid_r;

  // ========================================================================
  // Queue bookkeeping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_r  <= '0;
      posted_r <= '0;
      wr_cmp_o <= 1'b0;
    end else begin
      valid_r  <= valid_nxt;
      posted_r <= posted_nxt;
      wr_cmp_o <= wr_take_w || merge_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_take_w) begin
      addr_r[free_idx_w] <= wr_addr_i;
      pch_r[free_idx_w]  <= wr_pch_i;
      be_r[free_idx_w]   <= wr_be_i;
    end else if (merge_w) begin
      be_r[wr_hidx_w] <= be_r[wr_hidx_w] | wr_be_i;
    end
  end

  // Only written bytes go to DRAM with their byte enables, so no underfill read is made.
  wqem_mem #(
    .DEPTH (DEPTH),
    .BEW   (BEW),
    .DW    (BEW * WQEM_BYTE)
  ) u_mem (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_en_i    (wr_take_w || merge_w),
    .wr_idx_i   (merge_w ? wr_hidx_w : free_idx_w),
    .wr_be_i    (wr_be_i),
    .wr_data_i  (wr_data_i),
    .rda_en_i   (rd_valid_i && rd_hit_w),
    .rda_idx_i  (rd_idx_w),
    .rda_data_o (rd_data_o),
    .rdb_en_i   (iss_go_w),
    .rdb_idx_i  (pick_w),
    .rdb_data_o (dram_wr_data_o)
  );

  // ========================================================================
  // Read path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_hit_o        <= 1'b0;
      dram_rd_valid_o <= 1'b0;
      dram_rd_pch_o   <= 1'b0;
      dram_rd_addr_o  <= '0;
    end else begin
      rd_hit_o        <= rd_valid_i && rd_hit_w;
      dram_rd_valid_o <= rd_valid_i && !rd_hit_w;
      dram_rd_pch_o   <= rd_pch_i;
      dram_rd_addr_o  <= rd_addr_i;
    end
  end

  // ========================================================================
  // DRAM issue
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r          <= WQEM_ISS_IDLE;
      infl_r           <= '0;
      dram_wr_valid_o  <= 1'b0;
      dram_wr_pch_o    <= 1'b0;
      dram_wr_addr_o   <= '0;
      dram_wr_be_o     <= '0;
      credit_ret_o     <= 1'b0;
      credit_ret_pch_o <= 1'b0;
    end else begin
      credit_ret_o     <= iss_done_w;
      credit_ret_pch_o <= iss_done_w && pch_r[infl_r];
      case (state_r)
        WQEM_ISS_IDLE: begin
          if (cand_any_w) begin
            state_r         <= WQEM_ISS_SEND;
            infl_r          <= pick_w;
            dram_wr_valid_o <= 1'b1;
            dram_wr_pch_o   <= pch_r[pick_w];
            dram_wr_addr_o  <= addr_r[pick_w];
            dram_wr_be_o    <= be_r[pick_w];
          end
        end
        WQEM_ISS_SEND: begin
          if (dram_wr_ready_i) begin
            state_r         <= WQEM_ISS_IDLE;
            dram_wr_valid_o <= 1'b0;
          end
        end
        default: begin
          state_r <= WQEM_ISS_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Event selection
  wire [7:0]       code_w   = ctl_r[WQEM_CTL_EV_LSB +: 8];
  wire [7:0]       um_w     = ctl_r[WQEM_CTL_UM_LSB +: 8];
  wire             en_w     = ctl_r[WQEM_CTL_EN_BIT];
  wire [1:0]       pch_um_w = {um_w[WQEM_UM_PSEUDO_CHANNEL_ONE], um_w[WQEM_UM_PSEUDO_CHANNEL_ZERO]};
  wire             no_filt_w = !um_w[WQEM_UM_NOT_POSTED] && !um_w[WQEM_UM_POSTED];
  wire [DEPTH-1:0] filt_w   = ((um_w[WQEM_UM_NOT_POSTED] || no_filt_w) ? ~posted_r : '0)
                            | ((um_w[WQEM_UM_POSTED] || no_filt_w) ? posted_r : '0);
  wire [CNTW-1:0]  occ0_w   = pop_count(valid_r & ~pch_r & filt_w);
  wire [CNTW-1:0]  occ1_w   = pop_count(valid_r & pch_r & filt_w);
  wire [WQEM_UM_TAG_W-1:0] tag_sel_w = {tag_write_i && tag_hit_i, !tag_write_i && tag_hit_i,
                                        !tag_hit_i && tag_dirty_i, !tag_hit_i && !tag_dirty_i,
                                        tag_hit_i};
  wire             tag_ev_w = tag_valid_i && |(um_w[WQEM_UM_TAG_W-1:0] & tag_sel_w);
  wire [1:0]       ne_w     = {cnt1_w != '0, cnt0_w != '0};
  wire [1:0]       alloc_w  = {wr_take_w && wr_pch_i, wr_take_w && !wr_pch_i};
  wire [1:0]       rmev_w   = {rd_valid_i && rd_hit_w && rd_pch_i,
                               rd_valid_i && rd_hit_w && !rd_pch_i};
  wire [1:0]       wmev_w   = {merge_w && wr_pch_i, merge_w && !wr_pch_i};
  wire [CNTW-1:0]  inc_w    =
      (code_w == WQEM_EV_TAG_CHECK)   ? CNTW'(tag_ev_w) :
      (code_w == WQEM_EV_FULL_PSEUDO_CHANNEL_ZERO)   ? CNTW'(full0_w) :
      (code_w == WQEM_EV_FULL_PSEUDO_CHANNEL_ONE)   ? CNTW'(full1_w) :
      (code_w == WQEM_EV_NONEMPTY)    ? CNTW'(|(ne_w & pch_um_w)) :
      (code_w == WQEM_EV_ALLOC)       ? CNTW'(|(alloc_w & pch_um_w)) :
      (code_w == WQEM_EV_OCC_PSEUDO_CHANNEL_ZERO)    ? occ0_w :
      (code_w == WQEM_EV_OCC_PSEUDO_CHANNEL_ONE)    ? occ1_w :
      (code_w == WQEM_EV_READ_MATCH)  ? CNTW'(|(rmev_w & pch_um_w)) :
      (code_w == WQEM_EV_WRITE_MATCH) ? CNTW'(|(wmev_w & pch_um_w)) : '0;

  // ========================================================================
  // Register bus
  wire        wb_req_w  = wb_cyc_i && wb_stb_i && !ack_r;
  wire        ctl_wr_w  = wb_req_w && wb_we_i && wb_adr_i == WQEM_OFF_CTL;
  wire        cnt_wr_w  = wb_req_w && wb_we_i && wb_adr_i == WQEM_OFF_CNT;
  wire [31:0] stat_w    = 32'(cnt0_w) | (32'(cnt1_w) << WQEM_ST_OCC1_LSB)
                        | (32'(full0_w) << WQEM_ST_FULL0_BIT)
                        | (32'(full1_w) << WQEM_ST_FULL1_BIT)
                        | (32'(busy_w) << WQEM_ST_BUSY_BIT);
  wire [31:0] rdata_w   = (wb_adr_i == WQEM_OFF_CTL)  ? ctl_r :
                          (wb_adr_i == WQEM_OFF_CNT)  ? cnt_r :
                          (wb_adr_i == WQEM_OFF_STAT) ? stat_w : '0;

  // A software write to the counter wins over that cycle's increment.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      wb_dat_o <= '0;
      ctl_r    <= WQEM_CTL_RST;
      cnt_r    <= WQEM_CNT_RST;
    end else begin
      ack_r    <= wb_req_w;
      wb_dat_o <= wb_req_w ? rdata_w : '0;
      if (ctl_wr_w) ctl_r <= byte_merge(ctl_r, wb_dat_i, wb_sel_i);
      if (cnt_wr_w) cnt_r <= byte_merge(cnt_r, wb_dat_i, wb_sel_i);
      else if (en_w) cnt_r <= cnt_r + 32'(inc_w);
    end
  end
  assign wb_ack_o = ack_r;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_issue_start;
    iss_go_w ##1 (dram_wr_valid_o && busy_w);
  endsequence
  sequence s_issue_end;
    iss_done_w ##1 (credit_ret_o && !dram_wr_valid_o);
  endsequence

  tag_hit_count_a: assert property (
    (en_w && code_w == WQEM_EV_TAG_CHECK && um_w[WQEM_UM_HIT] && tag_valid_i && tag_hit_i
     && !cnt_wr_w) |=> cnt_r == $past(cnt_r) + 32'h1)
    else $error("tag hit not counted");
  full_count_a: assert property (
    (en_w && code_w == WQEM_EV_FULL_PSEUDO_CHANNEL_ZERO && !cnt_wr_w) |=> cnt_r == $past(cnt_r) + 32'($past(full0_w)))
    else $error("full cycle count wrong");
  full_refuse_a: assert property (
    (wr_valid_i && !wr_hit_w && wr_full_w) |=> !wr_cmp_o)
    else $error("write accepted while full");
  ne_count_a: assert property (
    (en_w && code_w == WQEM_EV_NONEMPTY && pch_um_w == 2'h1 && !cnt_wr_w && cnt0_w != '0)
    |=> cnt_r == $past(cnt_r) + 32'h1)
    else $error("non-empty cycle not counted");
  occ_limit_a: assert property (
    occ0_w <= cnt0_w && occ1_w <= cnt1_w && cnt0_w + cnt1_w <= CNTW'(DEPTH))
    else $error("occupancy out of range");
  issue_free_a: assert property (
    iss_go_w |-> s_issue_start)
    else $error("issue did not start");
  credit_back_a: assert property (
    iss_done_w |-> s_issue_end)
    else $error("credit not returned after issue");
  post_complete_a: assert property (
    wr_take_w |=> wr_cmp_o ##1 (posted_r == (valid_r & $past(valid_r))))
    else $error("completion not sent on posting");
  rd_hit_a: assert property (
    (rd_valid_i && rd_hit_w) |=> rd_hit_o && !dram_rd_valid_o)
    else $error("read match went to memory");
  rd_miss_a: assert property (
    (rd_valid_i && !rd_hit_w) |=> dram_rd_valid_o && !rd_hit_o && dram_rd_addr_o == $past(rd_addr_i))
    else $error("read miss not forwarded");
  merge_keep_a: assert property (
    (merge_w && !iss_done_w) |=> valid_r == $past(valid_r))
    else $error("matching write allocated a new entry");

endmodule : wqem_monitor

// file: sim/wqem_dram_model.sv
// Purpose: DRAM write port model that takes issued writes from the queue.
// Assumes: One clock, synchronous active-high reset.
// Notes:   While stalled it never answers, so queued writes pile up.
// ==========================================================================
// Model
module wqem_dram_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Issue handshake
  input  wire logic valid_i,
  input  wire logic stall_i,
  output logic      ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A one-cycle ready keeps each write accepted exactly once.
  always_ff @(posedge clk_i) begin
    ready_o <= !rst_i && valid_i && !stall_i && !ready_o;
  end
endmodule : wqem_dram_model

// file: sim/test_write_queue_event_monitor.sv
// Purpose: Self-checking bench for the write queue event monitor.
// Assumes: Classic Wishbone master, DRAM model stalls on request.
// Notes:   Counts are read back after each event burst has settled.
// ==========================================================================
// Bench
module test_write_queue_event_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  import wqem_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, stall = 1;
  logic tv = 0, th = 0, td = 0, tw = 0, wv = 0, wp = 0, rv = 0, rdy;
  logic [7:0]  adr = 0, be = 0, dwbe;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wd = 0, q, wa = 0, ra = 0, dato, dra, dwa;
  logic [63:0] wdat = 0, rdat, dwd;
  logic        ack, cmp, hit, drd, dwv, cret, cpch, dwp, drp;
  int          errors = 0, tests_run = 0;
  int          ncred = 0, ncp1 = 0;
  always #20 clk_i = ~clk_i;
  wqem_monitor dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dato),
    .wb_ack_o(ack), .tag_valid_i(tv), .tag_hit_i(th), .tag_dirty_i(td), .tag_write_i(tw),
    .wr_valid_i(wv), .wr_pch_i(wp), .wr_addr_i(wa), .wr_be_i(be), .wr_data_i(wdat),
    .wr_cmp_o(cmp), .credit_ret_o(cret), .credit_ret_pch_o(cpch), .rd_valid_i(rv),
    .rd_pch_i(1'b0), .rd_addr_i(ra), .rd_hit_o(hit), .rd_data_o(rdat), .dram_rd_valid_o(drd),
    .dram_rd_pch_o(drp), .dram_rd_addr_o(dra), .dram_wr_valid_o(dwv), .dram_wr_ready_i(rdy),
    .dram_wr_pch_o(dwp), .dram_wr_addr_o(dwa), .dram_wr_be_o(dwbe), .dram_wr_data_o(dwd));
  wqem_dram_model dram_u (.clk_i(clk_i), .rst_i(rst_i), .valid_i(dwv), .stall_i(stall),
    .ready_o(rdy));
  always @(posedge clk_i) begin
    if (cret === 1'b1) begin
      ncred++;
      if (cpch === 1'b1) ncp1++;
    end
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // The request stands until ack is seen; a silent slave is caught by the watchdog.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d; sel <= 4'hf;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1);
    q = dato;
    cyc <= 0; stb <= 0;
    chk("wb_wait", 2, n);
    @(posedge clk_i);
    chk("wb_ack", 0, ack);
  endtask : wb
  task automatic cnt(input logic [31:0] e);
    wb(0, WQEM_OFF_CNT, 0);
    chk("counter", e, q);
  endtask : cnt
  task automatic set(input logic [31:0] c);
    wb(1, WQEM_OFF_CTL, c);
    wb(1, WQEM_OFF_CNT, 0);
  endtask : set
  task automatic wr(input logic p, input logic [31:0] a, input logic [7:0] b,
                    input logic [63:0] d, input logic e);
    @(posedge clk_i);
    wv <= 1; wp <= p; wa <= a; be <= b; wdat <= d;
    @(posedge clk_i);
    wv <= 0;
    @(posedge clk_i);
    chk("wr_cmp", e, cmp);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic h);
    @(posedge clk_i);
    rv <= 1; ra <= a;
    @(posedge clk_i);
    rv <= 0;
    @(posedge clk_i);
    chk("rd_hit", h, hit);
    chk("dram_rd", !h, drd);
    if (!h) chk("dram_rd_addr", a, dra);
    if (!h) chk("dram_rd_pch", 0, drp);
    if (h) chk("rd_data", 64'hbbbbbbbb_aaaaaaaa, rdat);
  endtask : rd
  task automatic t_regs;
    wb(0, WQEM_OFF_CTL, 0);
    chk("ctl", WQEM_CTL_RST, q);
    cnt(WQEM_CNT_RST);
    wb(1, WQEM_OFF_STAT, 32'hffffffff);
    wb(0, WQEM_OFF_STAT, 0);
    chk("stat", 0, q);
    wb(0, 8'h0c, 0);
    chk("unmapped", 0, q);
  endtask : t_regs
  task automatic t_match;
    set(32'h0040_0120);
    wr(0, 32'h100, 8'hff, 0, 1);
    wr(0, 32'h200, 8'h0f, 64'haaaaaaaa, 1);
    wr(0, 32'h200, 8'hf0, 64'hbbbbbbbb_00000000, 1);
    cnt(2);
    set(32'h0040_0124);
    wr(0, 32'h200, 8'hf0, 64'hbbbbbbbb_00000000, 1);
    cnt(1);
    set(32'h0040_0123);
    rd(32'h200, 1);
    rd(32'h300, 0);
    cnt(1);
    wb(0, WQEM_OFF_STAT, 0);
    chk("pseudo_channel_zero_entries", 2, q[5:0]);
  endtask : t_match
  task automatic t_full;
    set(32'h0040_0016);
    for (int i = 0; i < 20; i++) wr(1, 32'h1000 + 32'(i * 64), 8'hff, 64'(i), 1);
    wb(0, WQEM_OFF_STAT, 0);
    chk("pseudo_channel_one_full", 1, q[WQEM_ST_FULL1_BIT]);
    wr(1, 32'h5000, 8'hff, 0, 0);
  endtask : t_full
  // With the DRAM side stalled the queue is frozen, so each count is three cycles of one rate.
  task automatic t_occ;
    set(32'h0040_0016);
    cnt(3);
    set(32'h0040_0022);
    cnt(0);
    set(32'h0040_0083);
    cnt(60);
    set(32'h0040_0283);
    cnt(60);
    set(32'h0040_0183);
    cnt(0);
    set(32'h0040_0082);
    cnt(6);
    set(32'h0040_0321);
    cnt(3);
  endtask : t_occ
  task automatic t_drain;
    int n;
    n = 0;
    chk("dram_wr_valid", 1, dwv);
    chk("dram_wr_addr", 32'h100, dwa);
    chk("dram_wr_pch", 0, dwp);
    chk("dram_wr_be", 8'hff, dwbe);
    chk("dram_wr_data", 0, dwd);
    stall <= 0;
    do begin wb(0, WQEM_OFF_STAT, 0); n++; end while (q[13:0] !== 0 && n < 60);
    chk("drained", 0, q[13:0]);
    chk("credits", 22, ncred);
    chk("credits_pseudo_channel_one", 20, ncp1);
  endtask : t_drain
  task automatic t_tag;
    set(32'h0040_05d3);
    @(posedge clk_i);
    tv <= 1; th <= 1;
    @(posedge clk_i);
    th <= 0;
    @(posedge clk_i);
    td <= 1;
    @(posedge clk_i);
    tv <= 0; td <= 0;
    cnt(2);
    set(32'h0040_10d3);
    @(posedge clk_i);
    tv <= 1; th <= 1; tw <= 0;
    @(posedge clk_i);
    tw <= 1;
    @(posedge clk_i);
    tv <= 0; th <= 0; tw <= 0;
    cnt(1);
  endtask : t_tag
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    t_regs();
    t_match();
    t_full();
    t_occ();
    t_drain();
    t_tag();
    print_verdict();
  end
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule : test_write_queue_event_monitor
